/* test/power_on_reset_config_sequencer_bench.sv */
// Purpose: Self-checking bench of the power-on reset sequencer
// Assumes: PLL lock shortened to 20 divided ticks, bus tick every cycle
// Notes:   Delays are counted between edges of the reset outputs
`timescale 1ns/10ps
`default_nettype none
module power_on_reset_config_sequencer_bench import prc_pkg::*;;
  localparam int LOCK = 20;
  localparam logic [31:0] DEF_W = 32'h5A5A00F1;
  logic aclk, aresetn, por_req, hard_reset_req_n, soft_reset_req_n;
  logic [13:0] strap_word;
  logic [13:0] strap_pins;
  logic power_on_reset_n, internal_por_n, system_pll_locked;
  logic hard_reset_n, soft_reset_n, cfg_master, cfg_word_valid;
  logic [13:0] strap_latched;
  logic host_cfg_valid, host_cfg_accept;
  logic [31:0] host_cfg_data, master_cfg_word, cfg_word;
  logic [3:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_total, n_tests;

  // ==========================================================
  // Design and reset source
  prc_sequencer #(.PLL_LOCK_TICKS(LOCK), .BUS_REF_DIV(1),
    .CFG_DEFAULT(DEF_W)) i_prc_sequencer (
    .aclk, .aresetn, .power_on_reset_n, .hard_reset_req_n,
    .soft_reset_req_n, .internal_por_n, .system_pll_locked,
    .hard_reset_n, .soft_reset_n,
    .reset_cfg_select(strap_pins[0]), .cfg_source_select(strap_pins[1]),
    .host_port_sync_select(strap_pins[2]),
    .host_port_width_select(strap_pins[3]),
    .chip_slot_number(strap_pins[7:4]),
    .boot_source_select(strap_pins[10:8]),
    .sw_watchdog_enable_strap(strap_pins[11]),
    .clock_mode_select(strap_pins[13:12]), .strap_latched, .cfg_master,
    .host_cfg_valid, .host_cfg_data, .host_cfg_accept, .master_cfg_word,
    .cfg_word, .cfg_word_valid, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  prc_reset_src #(.HOLD_CYC(16)) i_prc_reset_src (
    .aclk, .por_req, .strap_word, .power_on_reset_n, .strap_pins);

  // ==========================================================
  // Shared tasks
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic conclude;
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Response 3 never comes back here, so it marks a missing answer
  task automatic axi_wr(logic [3:0] a, logic [31:0] d,
                        output logic [1:0] r);
    int t;
    t = 0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (r === 2'h3 && t < 64) begin
      @(posedge aclk);
      t++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  task automatic axi_rd(logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int t;
    t = 0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (r === 2'h3 && t < 64) begin
      @(posedge aclk);
      t++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
  // Pulses the reset source and returns in the cycle of its release
  task automatic por_go(logic [13:0] s);
    int t;
    t = 0;
    @(posedge aclk);
    strap_word <= s;
    por_req <= 1'b1;
    @(posedge aclk);
    por_req <= 1'b0;
    do begin
      @(posedge aclk);
      #1;
      t++;
    end while (power_on_reset_n !== 1'b1 && t < 100);
  endtask
  // Edges until output 'which' rises; hard and soft stay low before lock
  task automatic meas(int which, int n0, output int n);
    logic [3:0] v;
    n = n0;
    v = 4'h0;
    while (v[which] !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      #1;
      n++;
      v = {soft_reset_n, hard_reset_n, system_pll_locked, internal_por_n};
      if (which < 2) begin
        chk("held", 0, 32'({hard_reset_n, soft_reset_n}));
      end
    end
  endtask
  task automatic flow(int n0, int lock_n);
    int n;
    meas(0, n0, n);
    chk("ipor delay", 1025, n);
    meas(1, 0, n);
    chk("lock delay", lock_n, n);
    meas(2, 0, n);
    chk("hard delay", 512, n);
    meas(3, 0, n);
    chk("soft delay", 3, n);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(REG_CTRL, d, r);
    chk("ctrl reset", 32'(CTRL_RESET), d);
    axi_rd(4'h2, d, r);
    chk("unmapped", 32'h0, d);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    axi_wr(REG_STATUS, 32'hFF, r);
    chk("status write", 32'(RESP_SLVERR), 32'(r));
    axi_wr(REG_CTRL, 32'h1, r);
    axi_rd(REG_CTRL, d, r);
    chk("ctrl", 32'h1, d);
  endtask
  task automatic t_host;
    logic [31:0] d;
    logic [1:0] r;
    por_go(14'h2A5E);
    @(posedge aclk);
    host_cfg_data <= 32'hC0FFEE01;
    host_cfg_valid <= 1'b1;
    #1;
    chk("accept", 1, 32'(host_cfg_accept));
    chk("straps", 32'h2A5E, 32'(strap_latched));
    chk("master", 1, 32'(cfg_master));
    @(posedge aclk);
    host_cfg_valid <= 1'b0;
    #1;
    chk("host word", 32'hC0FFEE01, cfg_word);
    flow(2, 2 * LOCK);
    axi_rd(REG_STRAPS, d, r);
    chk("straps kept", 32'h2A5E, d);
    @(posedge aclk);
    host_cfg_valid <= 1'b1;
    #1;
    chk("late accept", 0, 32'(host_cfg_accept));
    @(posedge aclk);
    host_cfg_valid <= 1'b0;
  endtask
  task automatic t_slave;
    logic [1:0] r;
    int n;
    axi_wr(REG_CTRL, 32'h0, r);
    por_go(14'h1D31);
    flow(0, LOCK);
    #50;
    chk("default", DEF_W, cfg_word);
    chk("valid", 1, 32'(cfg_word_valid));
    axi_wr(REG_CFG_WORD, 32'h12345678, r);
    chk("run write", 32'(RESP_SLVERR), 32'(r));
    @(posedge aclk);
    hard_reset_req_n <= 1'b0;
    @(posedge aclk);
    hard_reset_req_n <= 1'b1;
    axi_wr(REG_CFG_WORD, 32'hA5F00F5A, r);
    chk("hard write", 32'(RESP_OKAY), 32'(r));
    meas(3, 0, n);
    chk("hard word", 32'hA5F00F5A, cfg_word);
    // Soft request replays only the gap between hard and soft release
    @(posedge aclk);
    soft_reset_req_n <= 1'b0;
    @(posedge aclk);
    soft_reset_req_n <= 1'b1;
    meas(3, 0, n);
    chk("soft replay", 32'(SOFT_TICKS - HARD_TICKS), n);
    chk("hard kept", 1, 32'(hard_reset_n));
  endtask
  task automatic t_master;
    logic [1:0] r;
    por_go(14'h3C63);
    // Refused in power-on reset too, as the master role owns the word
    axi_wr(REG_CFG_WORD, 32'h1, r);
    chk("master por write", 32'(RESP_SLVERR), 32'(r));
    flow(4, LOCK);
    chk("master word", 32'h0BADCAFE, cfg_word);
    axi_wr(REG_CFG_WORD, 32'h1, r);
    chk("master write", 32'(RESP_SLVERR), 32'(r));
    @(posedge aclk);
    por_req <= 1'b1;
    @(posedge aclk);
    por_req <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
    chk("por outs", 0, {internal_por_n, system_pll_locked, hard_reset_n,
      soft_reset_n, cfg_word_valid, cfg_word[26:0]});
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Three flows of about 1600 cycles each fit well inside this span
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    conclude;
  end
  initial begin
    aresetn = 1'b0;
    por_req = 1'b0;
    hard_reset_req_n = 1'b1;
    soft_reset_req_n = 1'b1;
    strap_word = 14'h0;
    host_cfg_valid = 1'b0;
    host_cfg_data = 32'h0;
    master_cfg_word = 32'h0BADCAFE;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_bus;
    t_host;
    t_slave;
    t_master;
    conclude;
  end
endmodule
`default_nettype wire

/* test/prc_reset_src.sv */
// Purpose: Model of the board reset controller and its strap resistors
// Assumes: The bench asks for a power-on reset pulse with por_req
// Notes:   Straps are driven through their hold time, then inverted
`timescale 1ns/10ps
`default_nettype none
module prc_reset_src #(
  parameter int HOLD_CYC = 16
) (
  // Clock
  input wire logic aclk,
  // Bench requests
  input wire logic por_req,
  input wire logic [13:0] strap_word,
  // Pins towards the device
  output logic power_on_reset_n,
  output logic [13:0] strap_pins
);
  logic [7:0] hold_q;
  logic released_q;

  // ==========================================================
  // Power-on reset pulse
  initial begin
    power_on_reset_n = 1'b0;
    hold_q = 8'h00;
    released_q = 1'b0;
  end
  // Held low for HOLD_CYC cycles, never shorter, then released
  always @(posedge aclk) begin
    if (por_req) begin
      power_on_reset_n <= 1'b0;
      hold_q <= 8'(HOLD_CYC);
    end else if (hold_q != 8'h00) begin
      hold_q <= hold_q - 8'h01;
      power_on_reset_n <= (hold_q == 8'h01);
    end
    released_q <= power_on_reset_n & ~por_req;
  end

  // ==========================================================
  // Strap levels
  // Past the hold time the pins carry junk, so a late sample shows up
  assign strap_pins = released_q ? ~strap_word : strap_word;
endmodule
`default_nettype wire

/* verilog/prc_pkg.sv */
// Purpose: Shared constants and types of the power-on reset sequencer
// Assumes: aclk is the reference clock input at 20 MHz
// Notes:   Counts are in ticks of the clock or enable that drives them
package prc_pkg;

  // ==========================================================
  // Clock and sequence counts
  localparam int REF_CLK_HZ = 20000000;
  localparam int POR_MIN_CYC = 16;        // Held by the reset source
  localparam int CNT_W = 13;
  localparam logic [12:0] IPOR_CYC = 13'h400;   // 1024 ref cycles
  localparam int PLL_LOCK_DEF = 6400;           // Divided ref ticks
  localparam logic [12:0] HARD_TICKS = 13'h200; // 512 bus ref ticks
  localparam logic [12:0] SOFT_TICKS = 13'h203; // 515 bus ref ticks

  // ==========================================================
  // Strap word layout
  localparam int STRAP_W = 14;
  localparam int SB_RSTCFG = 0;      // 0 host port path, 1 system bus
  localparam int SB_CFGSRC = 1;      // 0 config slave, 1 config master
  localparam int SB_SYNC = 2;
  localparam int SB_WIDTH = 3;
  localparam int SB_SLOT = 4;        // 4 bits
  localparam int SB_BOOT = 8;        // 3 bits
  localparam int SB_WDOG = 11;
  localparam int SB_CLKMODE = 12;    // 2 bits

  // ==========================================================
  // Register map
  localparam int AXI_AW = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_STRAPS = 4'h8;
  localparam logic [3:0] REG_CFG_WORD = 4'hC;
  localparam logic CTRL_RESET = 1'h0;
  localparam logic [31:0] CFG_WORD_RESET = 32'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_HOLD, ST_IPOR, ST_PLL, ST_POST, ST_RUN
  } prc_state_t;

endpackage

/* verilog/prc_sequencer.sv */
// Purpose: Power-on reset flow, strap capture and reset config word load
// Assumes: Ref clock is aclk; PLL lock is modelled by a tick count
// Notes:   Registers over AXI4-Lite; unmapped or refused writes SLVERR
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Power-on reset low restarts the whole reset flow.
// - Config word loads through host slave port or system bus.
// - On system bus, a strap picks config master or slave role.
// - Slave role with no written word gets the built-in default.
// - Fourteen strap levels are latched as power-on reset releases.
// - Internal power-on reset releases 1025 ref cycles later.
// - PLL locks 6400 divided ref ticks after that; divide 1 or 2.
// - Hard reset releases 512 bus ref ticks after lock.
// - Soft reset releases 515 bus ref ticks after lock.
// - Host port config writes accepted only in power-on reset.
// - System bus config writes accepted in power-on or hard reset, in slave role only.
module prc_sequencer import prc_pkg::*; #(
  parameter int PLL_LOCK_TICKS = PLL_LOCK_DEF,
  parameter int BUS_REF_DIV = 1,
  parameter logic [31:0] CFG_DEFAULT = 32'h0  // Built-in default word
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reset pins
  input wire logic power_on_reset_n,
  input wire logic hard_reset_req_n,
  input wire logic soft_reset_req_n,
  output logic internal_por_n,
  output logic system_pll_locked,
  output logic hard_reset_n,
  output logic soft_reset_n,
  // Strap levels
  input wire logic reset_cfg_select,
  input wire logic cfg_source_select,
  input wire logic host_port_sync_select,
  input wire logic host_port_width_select,
  input wire logic [3:0] chip_slot_number,
  input wire logic [2:0] boot_source_select,
  input wire logic sw_watchdog_enable_strap,
  input wire logic [1:0] clock_mode_select,
  // Latched straps
  output logic [STRAP_W-1:0] strap_latched,
  output logic cfg_master,
  // Config word paths
  input wire logic host_cfg_valid,
  input wire logic [31:0] host_cfg_data,
  output logic host_cfg_accept,
  input wire logic [31:0] master_cfg_word,
  output logic [31:0] cfg_word,
  output logic cfg_word_valid,
  // AXI4-Lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  prc_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [STRAP_W-1:0] straps_q;
  logic ipor_q, lock_q, hard_q, soft_q;
  logic por_flow_q, hard_flow_q, cfg_written_q, cfg_valid_q;
  logic [31:0] cfg_q;
  logic div2_q;
  logic ref_tick, bus_tick, path_sys, slave_role, sys_wr_ok;
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_wr, cfg_wr_hit, do_rd;

  // ==========================================================
  // Enables: divided ref clock for the PLL, bus ref clock
  prc_tick_div #(.W(2)) u_ref_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr_i(st_q != ST_PLL),
    .div_i(div2_q ? 2'h2 : 2'h1),
    .tick_o(ref_tick)
  );

  prc_tick_div #(.W(8)) u_bus_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr_i(!power_on_reset_n),
    .div_i(8'(BUS_REF_DIV)),
    .tick_o(bus_tick)
  );

  // ==========================================================
  // Sequence next state; the PLL is only reset by power-on reset
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    if (!power_on_reset_n) begin
      st_d = ST_HOLD;
      cnt_d = '0;
    end else begin
      case (st_q)
        ST_HOLD: begin
          st_d = ST_IPOR;
          cnt_d = '0;
        end
        ST_IPOR: begin
          cnt_d = cnt_q + CNT_W'(1);
          if (cnt_q == IPOR_CYC - CNT_W'(1)) begin
            st_d = ST_PLL;
            cnt_d = '0;
          end
        end
        ST_PLL: begin
          if (ref_tick) begin
            cnt_d = cnt_q + CNT_W'(1);
            if (cnt_q == CNT_W'(PLL_LOCK_TICKS - 1)) begin
              st_d = ST_POST;
              cnt_d = '0;
            end
          end
        end
        ST_POST: begin
          if (!hard_reset_req_n) begin
            cnt_d = '0;
          end else if (bus_tick) begin
            cnt_d = cnt_q + CNT_W'(1);
            if (cnt_q == SOFT_TICKS - CNT_W'(1)) begin
              st_d = ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (!hard_reset_req_n) begin
            st_d = ST_POST;
            cnt_d = '0;
          end else if (!soft_reset_req_n) begin
            st_d = ST_POST;  // Replays only the last three ticks
            cnt_d = HARD_TICKS;
          end
        end
        default: begin
          st_d = ST_HOLD;
          cnt_d = '0;
        end
      endcase
    end
  end

  // State and counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_HOLD;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // Registered reset outputs, low until each release point
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ipor_q <= 1'b0;
      lock_q <= 1'b0;
      hard_q <= 1'b0;
      soft_q <= 1'b0;
    end else begin
      ipor_q <= (st_d == ST_PLL) || (st_d == ST_POST) || (st_d == ST_RUN);
      lock_q <= (st_d == ST_POST) || (st_d == ST_RUN);
      hard_q <= (st_d == ST_RUN) ||
                ((st_d == ST_POST) && (cnt_d >= HARD_TICKS));
      soft_q <= (st_d == ST_RUN);
    end
  end

  assign internal_por_n = ipor_q;
  assign system_pll_locked = lock_q;
  assign hard_reset_n = hard_q;
  assign soft_reset_n = soft_q;

  // ==========================================================
  // Straps caught on the first cycle after power-on reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      straps_q <= '0;
    end else if (st_q == ST_HOLD && power_on_reset_n) begin
      straps_q <= {clock_mode_select, sw_watchdog_enable_strap,
                   boot_source_select, chip_slot_number,
                   host_port_width_select, host_port_sync_select,
                   cfg_source_select, reset_cfg_select};
    end
  end

  assign strap_latched = straps_q;
  assign cfg_master = straps_q[SB_CFGSRC];
  assign path_sys = straps_q[SB_RSTCFG];
  assign slave_role = !straps_q[SB_CFGSRC];

  // Which kind of reset flow is under way; cleared when running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_flow_q <= 1'b1;
      hard_flow_q <= 1'b0;
    end else if (!power_on_reset_n) begin
      por_flow_q <= 1'b1;
      hard_flow_q <= 1'b0;
    end else if (st_d == ST_RUN) begin
      por_flow_q <= 1'b0;
      hard_flow_q <= 1'b0;
    end else if (!hard_reset_req_n && lock_q) begin
      hard_flow_q <= 1'b1;
    end
  end

  // ==========================================================
  // Config word loading
  assign host_cfg_accept = host_cfg_valid && !path_sys &&
                           por_flow_q && power_on_reset_n;
  assign sys_wr_ok = path_sys && slave_role &&
                     (por_flow_q || hard_flow_q);
  assign cfg_wr_hit = do_wr && (aw_addr_q == REG_CFG_WORD) && sys_wr_ok;

  // One writer process; a late write still beats the default
  always_ff @(posedge aclk) begin
    if (!aresetn || !power_on_reset_n) begin
      cfg_q <= CFG_WORD_RESET;
      cfg_written_q <= 1'b0;
      cfg_valid_q <= 1'b0;
    end else begin
      if (host_cfg_accept) begin
        cfg_q <= host_cfg_data;
        cfg_written_q <= 1'b1;
      end else if (cfg_wr_hit) begin
        for (int i = 0; i < 4; i++) begin
          if (w_strb_q[i]) begin
            cfg_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
          end
        end
        cfg_written_q <= 1'b1;
      end else if (st_q == ST_IPOR && st_d == ST_PLL &&
                   path_sys && !slave_role) begin
        cfg_q <= master_cfg_word;
        cfg_written_q <= 1'b1;
      end else if (hard_q == 1'b0 && st_d != ST_HOLD && lock_q &&
                   (cnt_d >= HARD_TICKS) && !cfg_written_q &&
                   path_sys && slave_role) begin
        cfg_q <= CFG_DEFAULT;
      end
      if (soft_q) begin
        cfg_valid_q <= 1'b1;
      end
    end
  end

  assign cfg_word = cfg_q;
  assign cfg_word_valid = cfg_valid_q;

  // ==========================================================
  // AXI4-Lite write side; address and data taken in either order
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign do_wr = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_wr) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // Write effect and response; refused config writes answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      div2_q <= CTRL_RESET;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= RESP_SLVERR;
      if (aw_addr_q == REG_CTRL) begin
        bresp_q <= RESP_OKAY;
        if (w_strb_q[0]) begin
          div2_q <= w_data_q[0];
        end
      end else if (cfg_wr_hit) begin
        bresp_q <= RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ==========================================================
  // AXI4-Lite read side, answer one cycle after the address
  assign s_axi_arready = !rvalid_q;
  assign do_rd = s_axi_arvalid && !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (do_rd) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: rdata_q <= {31'h0, div2_q};
        REG_STATUS: rdata_q <= {22'h0, cfg_written_q, hard_flow_q,
                                por_flow_q, soft_q, hard_q, lock_q,
                                ipor_q, st_q};
        REG_STRAPS: rdata_q <= {18'h0, straps_q};
        REG_CFG_WORD: rdata_q <= cfg_q;
        default: begin
          rdata_q <= '0;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================================
  // Checks
  AST_POR_START: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !power_on_reset_n |=> !hard_reset_n && !soft_reset_n &&
    !internal_por_n) else $error("reset outputs not held in POR");
  AST_HOLD_ORDER: assert property (
    @(posedge aclk) disable iff (!aresetn)
    soft_reset_n |-> hard_reset_n && system_pll_locked)
    else $error("soft released before hard or lock");
  AST_STRAP_LATCH: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_q == ST_HOLD && power_on_reset_n) |=>
    strap_latched[SB_BOOT +: 3] == $past(boot_source_select))
    else $error("straps not latched on release");
  AST_STRAP_STABLE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_q != ST_HOLD && $past(st_q) != ST_HOLD) |-> $stable(strap_latched))
    else $error("straps changed outside release");
  AST_IPOR_DELAY: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(internal_por_n) |-> $past(cnt_q) == IPOR_CYC - CNT_W'(1))
    else $error("internal POR released at wrong count");
  AST_PLL_LOCK: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(system_pll_locked) |->
    $past(cnt_q) == CNT_W'(PLL_LOCK_TICKS - 1) && $past(ref_tick))
    else $error("lock at wrong divided tick count");
  AST_HARD_REL: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(hard_reset_n) && $past(st_q) == ST_POST |->
    cnt_q == HARD_TICKS) else $error("hard reset release count");
  AST_SOFT_REL: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(soft_reset_n) |-> cnt_q == SOFT_TICKS && hard_reset_n)
    else $error("soft reset release count");
  AST_HOST_WR: assert property (
    @(posedge aclk) disable iff (!aresetn)
    host_cfg_accept |-> !soft_reset_n && !hard_flow_q && !path_sys)
    else $error("host config write outside POR");
  AST_SYS_WR: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cfg_wr_hit |=> s_axi_bresp == RESP_OKAY && !soft_reset_n)
    else $error("system bus config write in wrong reset");

endmodule
`default_nettype wire

/* verilog/prc_tick_div.sv */
// Purpose: Enable pulse generator dividing aclk by a run-time factor
// Assumes: div_i is at least one
// Notes:   clr_i restarts the phase so the first tick is predictable
`timescale 1ns/10ps
`default_nettype none
module prc_tick_div #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic clr_i,
  input wire logic [W-1:0] div_i,
  // Enable out
  output logic tick_o
);

  logic [W-1:0] cnt_q;

  // ==========================================================
  // Pulse on the last count of each period
  assign tick_o = (cnt_q == div_i - W'(1)) || (div_i == W'(1));

  // Phase counter, wraps on the tick
  always_ff @(posedge aclk) begin
    if (!aresetn || clr_i || tick_o) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

endmodule
`default_nettype wire
